// ===== design/rsc_map.vh
// reset combiner constants: field positions, reset values, encodings
// assumes inclusion by bare name from design files
`ifndef RSC_MAP_VH
`define RSC_MAP_VH
// register offsets on the plain register port
`define RSC_ADDR_W        4
`define RSC_OFF_CAUSE     4'h0
`define RSC_OFF_OSC       4'h1
`define RSC_OFF_CONFIG    4'h2
// reset cause register fields
`define RSC_BIT_TRAP      15
`define RSC_BIT_BADOP     14
`define RSC_BIT_SOFT_BROWNOUT_ENABLE    13
`define RSC_BIT_DEEP_SLEEP_FLAG     10
`define RSC_BIT_FBIAS     8
`define RSC_BIT_PIN       7
`define RSC_BIT_SWR       6
`define RSC_BIT_SWDT      5
`define RSC_BIT_WATCHDOG_TIMEOUT_FLAG      4
`define RSC_BIT_SLEEP     3
`define RSC_BIT_IDLE      2
`define RSC_BIT_BOR       1
`define RSC_BIT_POR       0
`define RSC_CAUSE_MASK    16'hE5FF
`define RSC_CAUSE_POR_VAL 16'h0003
// brown-out configuration under software control
`define RSC_BORCFG_SOFT   2'h1
// oscillator control field of current selection
`define RSC_OSC_LO        12
`define RSC_OSC_RESET     16'h0000
`endif

// ===== design/rsc_sync.v
// two-flop synchroniser for one level from outside the clock domain
// assumes clk is the combiner clock; reset is asynchronous active high
`default_nettype none
module rsc_sync
(
  // clock and reset
  input  wire clk,
  input  wire reset,
  // level in and out
  input  wire din,
  output wire dout
);
  reg stage1Q;
  reg stage2Q;
  // ===================================
  // sync chain: first stage read only by second
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      stage1Q <= 1'b0;
      stage2Q <= 1'b0;
    end
    else
    begin
      stage1Q <= din;
      stage2Q <= stage1Q;
    end
  end
  assign dout = stage2Q;
endmodule
`default_nettype wire

// ===== design/rsc_reset_combiner.v
// reset combiner: merges reset sources into one master reset, logs the cause
// assumes all event inputs except the pin and brown-out come from logic on clk
`default_nettype none
`include "rsc_map.vh"
module rsc_reset_combiner
(
  // clock and power-up reset
  input  wire        clk,
  input  wire        reset,
  // raw sources from outside the domain
  input  wire        externalPinResetN,
  input  wire        brownoutDetect,
  // sources from logic on clk
  input  wire        resetInstr,
  input  wire        watchdogTimeout,
  input  wire        trapConflict,
  input  wire        badOpcode,
  input  wire        deepSleepWake,
  // power state from the core
  input  wire        sleepMode,
  input  wire        idleMode,
  // configuration bits
  input  wire        watchdogFuseEnable,
  input  wire        clockSwitchEnable,
  input  wire [2:0]  initialOscSelect,
  input  wire [1:0]  brownoutConfig,
  // register port
  input  wire [3:0]  regAddr,
  input  wire [15:0] regWdata,
  input  wire        regWrite,
  input  wire        regRead,
  output reg  [15:0] regRdata,
  // outputs to core and peripherals
  output wire        masterResetLine,
  output wire        watchdogRun,
  output wire        brownoutEnable,
  output wire        wakeRequest,
  output wire        flashBiasInSleep,
  output reg  [2:0]  sysClockSelect
);
  wire       pinResetSync;
  wire       borSync;
  wire       pinReset;
  wire       brownoutReset;
  wire       watchdogReset;
  wire       powerUpActive;
  wire       softBorEnable;
  wire       anySource;
  wire       cosAfterReset;
  reg  [15:0] causeQ;
  reg  [15:0] causeD;
  reg  [2:0]  curOscQ;
  reg         porHoldQ;
  reg         swrPulseQ;
  reg         lowPowerQ;

  // ===================================
  // synchronise pin and brown-out; a pin low caught at any edge passes through one cycle later
  rsc_sync uPinSync
  (
    .clk   (clk),
    .reset (reset),
    .din   (~externalPinResetN),
    .dout  (pinResetSync)
  );
  rsc_sync uBorSync
  (
    .clk   (clk),
    .reset (reset),
    .din   (brownoutDetect),
    .dout  (borSync)
  );

  // ===================================
  // power-up hold: one cycle after release so the clock choice settles
  always @(posedge clk or posedge reset)
  begin
    if (reset)
      porHoldQ <= 1'b1;
    else
      porHoldQ <= 1'b0;
  end
  assign powerUpActive = reset | porHoldQ;

  // ===================================
  // instruction reset is a single-cycle pulse, released next cycle
  always @(posedge clk or posedge reset)
  begin
    if (reset)
      swrPulseQ <= 1'b0;
    else
      swrPulseQ <= resetInstr & ~swrPulseQ;
  end

  // ===================================
  // brown-out enable: soft bit only counts in the soft configuration
  assign softBorEnable = (brownoutConfig == `RSC_BORCFG_SOFT) & causeQ[`RSC_BIT_SOFT_BROWNOUT_ENABLE];
  assign brownoutEnable = (brownoutConfig == `RSC_BORCFG_SOFT) ? softBorEnable :
                          (brownoutConfig != 2'h0) & ~((brownoutConfig == 2'h2) & sleepMode);
  assign brownoutReset = borSync & brownoutEnable;
  assign pinReset = pinResetSync;

  // ===================================
  // watchdog: fuse forces it on; timeout in low power only wakes
  assign watchdogRun   = watchdogFuseEnable | causeQ[`RSC_BIT_SWDT];
  assign watchdogReset = watchdogTimeout & watchdogRun & ~(sleepMode | idleMode);
  assign wakeRequest   = (watchdogTimeout & watchdogRun & (sleepMode | idleMode)) | deepSleepWake;

  // ===================================
  // master reset: or of every source except deepSleepWake, which only wakes
  assign anySource = powerUpActive | pinReset | swrPulseQ | watchdogReset |
                     brownoutReset | trapConflict | badOpcode;
  assign masterResetLine = anySource;
  assign flashBiasInSleep = causeQ[`RSC_BIT_FBIAS];

  // ===================================
  // cause register next value; hardware set beats software clear
  always @*
  begin
    causeD = causeQ;
    if (regWrite && regAddr == `RSC_OFF_CAUSE)
      causeD = regWdata & `RSC_CAUSE_MASK;
    if (trapConflict)
      causeD[`RSC_BIT_TRAP] = 1'b1;
    if (badOpcode)
      causeD[`RSC_BIT_BADOP] = 1'b1;
    if (deepSleepWake)
      causeD[`RSC_BIT_DEEP_SLEEP_FLAG] = 1'b1;
    if (pinReset)
      causeD[`RSC_BIT_PIN] = 1'b1;
    if (swrPulseQ)
      causeD[`RSC_BIT_SWR] = 1'b1;
    if (watchdogTimeout & watchdogRun)
      causeD[`RSC_BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
    if (lowPowerQ & sleepMode)
      causeD[`RSC_BIT_SLEEP] = 1'b1;
    if (lowPowerQ & idleMode)
      causeD[`RSC_BIT_IDLE] = 1'b1;
    if (brownoutReset)
      causeD[`RSC_BIT_BOR] = 1'b1;
    if (porHoldQ)
      causeD = `RSC_CAUSE_POR_VAL;
  end

  // ===================================
  // cause register; only power-up reloads it, other resets keep the flags
  always @(posedge clk or posedge reset)
  begin
    if (reset)
      causeQ <= `RSC_CAUSE_POR_VAL;
    else
      causeQ <= causeD;
  end

  // low-power entry marker so flags rise two cycles into the mode
  always @(posedge clk or posedge reset)
  begin
    if (reset)
      lowPowerQ <= 1'b0;
    else
      lowPowerQ <= sleepMode | idleMode;
  end

  // ===================================
  // clock choice after reset
  assign cosAfterReset = powerUpActive | brownoutReset;
  always @(posedge clk or posedge reset)
  begin
    if (reset)
      curOscQ <= 3'h0;
    else if (!clockSwitchEnable)
      curOscQ <= initialOscSelect;
    else if (cosAfterReset)
      curOscQ <= initialOscSelect;
    else if (regWrite && regAddr == `RSC_OFF_OSC)
      curOscQ <= regWdata[`RSC_OSC_LO+2:`RSC_OSC_LO];
  end

  // registered clock select; resets other than power-up and brown-out keep the current one
  always @(posedge clk or posedge reset)
  begin
    if (reset)
      sysClockSelect <= 3'h0;
    else
      sysClockSelect <= curOscQ;
  end

  // ===================================
  // read port: data one cycle after the strobe, zero elsewhere
  always @(posedge clk or posedge reset)
  begin
    if (reset)
      regRdata <= 16'h0000;
    else if (regRead)
    begin
      case (regAddr)
        `RSC_OFF_CAUSE:
          regRdata <= {causeQ[15:14], softBorEnable, causeQ[12:0]} & `RSC_CAUSE_MASK;
        `RSC_OFF_OSC:
          regRdata <= {1'b0, curOscQ, 12'h000};
        `RSC_OFF_CONFIG:
          regRdata <= {8'h00, watchdogRun, brownoutEnable, brownoutConfig, clockSwitchEnable, initialOscSelect};
        default:
          regRdata <= 16'h0000;
      endcase
    end
    else
      regRdata <= 16'h0000;
  end
endmodule
`default_nettype wire

// ===== tb/rsc_props_properties.sv
// checker: timing relations at the reset combiner ports
// assumes the bind below attaches it to every combiner instance
`default_nettype none
module rsc_props
(
  // clock and power-up reset
  input wire logic        clk,
  input wire logic        reset,
  // sources, modes, configuration
  input wire logic        resetInstr,
  input wire logic        watchdogTimeout,
  input wire logic        trapConflict,
  input wire logic        sleepMode,
  input wire logic        idleMode,
  input wire logic        watchdogFuseEnable,
  input wire logic        clockSwitchEnable,
  input wire logic [2:0]  initialOscSelect,
  input wire logic [1:0]  brownoutConfig,
  // register port and outputs
  input wire logic [3:0]  regAddr,
  input wire logic        regRead,
  input wire logic [15:0] regRdata,
  input wire logic        masterResetLine,
  input wire logic        watchdogRun,
  input wire logic        wakeRequest,
  input wire logic [2:0]  sysClockSelect
);
  // ==========
  // assertions
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // trap and awake timeout reach the master line in their own cycle
  chk_trap_reset: assert property (trapConflict |-> masterResetLine)
    else $error("trap conflict without master reset");
  chk_wdt_reset: assert property (
    watchdogTimeout && !sleepMode && !idleMode |-> masterResetLine)
    else $error("awake timeout without master reset");
  // in low power the timeout only wakes the core
  chk_wdt_wake: assert property (
    watchdogTimeout && (sleepMode || idleMode) |-> wakeRequest)
    else $error("timeout in low power gave no wake");
  chk_instr_next: assert property (resetInstr |=> masterResetLine)
    else $error("reset instruction lost");
  chk_fuse_run: assert property (watchdogFuseEnable |-> watchdogRun)
    else $error("fuse set but watchdog stopped");
  // cause read data: gated enable and unused bits
  chk_sbor_gate: assert property (
    $past(regRead && regAddr == 4'h0 && brownoutConfig != 2'h1) |-> !regRdata[13])
    else $error("soft brown-out enable seen outside its mode");
  chk_unused_zero: assert property (
    $past(regRead && regAddr == 4'h0) |-> regRdata[12:11] == 2'h0 && !regRdata[9])
    else $error("unused cause bits not zero");
  // register then output stage: settled by the third edge
  chk_switch_off: assert property (
    !clockSwitchEnable [*3] |-> sysClockSelect == initialOscSelect)
    else $error("clock select ignores configuration");
  cover property (wakeRequest);
  cover property (resetInstr ##1 masterResetLine);
  cover property (trapConflict);
endmodule
bind rsc_reset_combiner rsc_props u_props
(
  .clk(clk), .reset(reset), .resetInstr(resetInstr), .watchdogTimeout(watchdogTimeout),
  .trapConflict(trapConflict), .sleepMode(sleepMode), .idleMode(idleMode),
  .watchdogFuseEnable(watchdogFuseEnable), .clockSwitchEnable(clockSwitchEnable),
  .initialOscSelect(initialOscSelect), .brownoutConfig(brownoutConfig), .regAddr(regAddr),
  .regRead(regRead), .regRdata(regRdata), .masterResetLine(masterResetLine),
  .watchdogRun(watchdogRun), .wakeRequest(wakeRequest), .sysClockSelect(sysClockSelect)
);
`default_nettype wire

// ===== tb/rsc_core_model.sv
// partner: core side that issues one-cycle reset source pulses
// assumes the bench raises fire for one cycle with a code
`default_nettype none
module rsc_core_model
(
  // clock and request
  input wire logic       clk,
  input wire logic       fire,
  input wire logic [1:0] code,
  // pulses to the combiner
  output var logic       resetInstr,
  output var logic       watchdogTimeout,
  output var logic       trapConflict,
  output var logic       badOpcode
);
  timeunit 1ns;
  timeprecision 1ns;
  // quiet until the first request
  initial {resetInstr, watchdogTimeout, trapConflict, badOpcode} = 4'h0;
  // launched on the edge, like the real core, so no race with the sampler
  always @(posedge clk)
  begin
    resetInstr <= fire && code == 2'h0;
    watchdogTimeout <= fire && code == 2'h1;
    trapConflict <= fire && code == 2'h2;
    badOpcode <= fire && code == 2'h3;
  end
endmodule
`default_nettype wire

// ===== tb/rsc_reset_combiner_bench.sv
// bench: sources and register traffic for the reset combiner
// assumes rsc_map.vh on the include path
`default_nettype none
`include "rsc_map.vh"
module rsc_reset_combiner_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, reset = 1'b1, pinN = 1'b1, bod = 1'b0, fire = 1'b0, slp = 1'b0;
  logic idl = 1'b0, fuse = 1'b0, cse = 1'b1, rw = 1'b0, rr = 1'b0, ri, wt, tc, bo, mrl, wrun;
  logic [1:0]  code = 2'h0, cfg = 2'h1;
  logic [2:0]  iosc = 3'h3, sclk;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wd = 16'h0000, rd, expCause [0:7];
  int          errCount = 0, comparisons = 0, k;
  always #50 clk = ~clk;
  rsc_core_model u_core (.clk(clk), .fire(fire), .code(code), .resetInstr(ri),
    .watchdogTimeout(wt), .trapConflict(tc), .badOpcode(bo));
  rsc_reset_combiner u_dut (.clk(clk), .reset(reset), .externalPinResetN(pinN),
    .brownoutDetect(bod), .resetInstr(ri), .watchdogTimeout(wt), .trapConflict(tc),
    .badOpcode(bo), .deepSleepWake(1'b0), .sleepMode(slp), .idleMode(idl),
    .watchdogFuseEnable(fuse), .clockSwitchEnable(cse), .initialOscSelect(iosc),
    .brownoutConfig(cfg), .regAddr(addr), .regWdata(wd), .regWrite(rw), .regRead(rr),
    .regRdata(rd), .masterResetLine(mrl), .watchdogRun(wrun), .brownoutEnable(),
    .wakeRequest(), .flashBiasInSleep(), .sysClockSelect(sclk));
  // ==========
  // tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
  begin
    comparisons++;
    if (seen !== want)
    begin
      errCount++;
      $display("ERROR %0t: saw %h want %h", $time, seen, want);
    end
  end
  endtask
  task automatic close_out;
  begin
    if (errCount == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one-cycle strobes launched right after an edge
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
  begin
    @(posedge clk);
    rw <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    rw <= 1'b0;
  end
  endtask
  task automatic rdc(input logic [3:0] a, input logic [15:0] want);
  begin
    @(posedge clk);
    rr <= 1'b1;
    addr <= a;
    @(posedge clk);
    rr <= 1'b0;
    #1 check(rd, want);
  end
  endtask
  // one reset event, or a timeout wake in sleep or idle; soft brown-out and soft watchdog enables kept so both sources stay live
  task automatic hit(input int n);
  begin
    wr(`RSC_OFF_CAUSE, 16'h2020);
    if (n == 4)
    begin
      pinN <= 1'b0;
      cyc(4);
      #1 check({15'h0000, mrl}, 16'h0001);
      @(posedge clk);
      pinN <= 1'b1;
    end
    else if (n == 5)
    begin
      bod <= 1'b1;
      cyc(4);
      bod <= 1'b0;
    end
    else
    begin
      slp <= (n == 6);
      idl <= (n == 7);
      cyc(3);
      fire <= 1'b1;
      code <= (n > 5) ? 2'h1 : 2'(n);
      cyc(1);
      fire <= 1'b0;
      cyc(3);
      slp <= 1'b0;
      idl <= 1'b0;
    end
    cyc(6);
    rdc(`RSC_OFF_CAUSE, expCause[n]);
  end
  endtask
  // ==========
  // sequence
  initial
  begin
    expCause = '{16'h2060, 16'h2030, 16'hA020, 16'h6020, 16'h20A0, 16'h2022, 16'h2038, 16'h2034};
    cyc(12);
    reset <= 1'b0;
    cyc(2);
    for (k = 0; k < 8 && mrl !== 1'b0; k++)
      @(posedge clk);
    if (k == 8)
    begin
      errCount++;
      close_out;
    end
    rdc(`RSC_OFF_CAUSE, `RSC_CAUSE_POR_VAL);
    wr(`RSC_OFF_CAUSE, 16'hFFFF);
    rdc(`RSC_OFF_CAUSE, `RSC_CAUSE_MASK);
    check({15'h0000, mrl}, 16'h0000);
    wr(`RSC_OFF_OSC, 16'h5000);
    // brown-out sixth: from then on the initial select holds
    for (k = 0; k < 8; k++)
    begin
      hit(k);
      check({13'h0000, sclk}, (k >= 5) ? 16'h0003 : 16'h0005);
    end
    cfg <= 2'h0;
    rdc(`RSC_OFF_CAUSE, 16'h0034);
    cse <= 1'b0;
    iosc <= 3'h6;
    fuse <= 1'b1;
    wr(`RSC_OFF_CAUSE, 16'h0000);
    cyc(3);
    #1 check({13'h0000, sclk}, 16'h0006);
    check({15'h0000, wrun}, 16'h0001);
    close_out;
  end
endmodule
`default_nettype wire
